// ### design/irq_flag_enable_bank.sv
/*
  Interrupt flag and enable bank: four flag registers set by peripheral
  events, one enable register, a read-only pending summary, an Avalon-MM
  slave and the request outputs toward the CPU arbitration logic.
  Assumes all event inputs are one-cycle pulses already on ref_clk, and that
  the enables of flag registers b..e and the flags matching enable register a
  live in neighbouring blocks and arrive on ports.
*/
// Local design decisions: the Avalon-MM register port and the address map.
`timescale 1ns/1ns
`include "irq_bank_regs.svh"

// Contract
// - a flag bit reads 1 once its source has requested and 0 otherwise.
// - an enable bit at 1 passes its source's request and at 0 blocks it.
// - unimplemented bits ignore writes and always read zero.
// - power-on reset clears every implemented flag and enable bit.
// - software can read and write every implemented flag and enable bit.
// - in flags b, bit 3 is pin change, bit 2 is absent, bits 1 and 0 are i2c a master and slave.
// - in flags c, bits 15..8 are timer six, dma 4, absent, output compare 8..5, capture 6.
// - in flags c, bits 7..0 are capture 5..3, dma 3, can a event, can a rx, spi b event and error.
// - in flags d, bits 15,14,10,9 are absent; 13 dma 5, 12 codec event, 11 codec error, 8 can b.
// - in flags d, bits 7..0 are can b rx, ext 4, ext 3, timers nine, eight, i2c b, timer seven.
// - in flags e, bits 15..8, 3 and 0 are absent; 7..4 can tx requests and dma 7,6; 2,1 uart errors.
// - in enables a, bit 15 is absent and bits 14..8 enable dma 1, adc a, uart a, spi a, timer 3.
// - in enables a, bits 7..0 enable timer 2, oc 2, ic 2, dma 0, timer 1, oc 1, ic 1, ext 0.
module irq_flag_enable_bank (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // register bus
  input wire irq_bank_pkg::avmm_req_type avs_req,
  output irq_bank_pkg::avmm_rsp_type avs_rsp,
  // peripheral events
  input wire irq_bank_pkg::flags_b_evt_type evt_b,
  input wire irq_bank_pkg::flags_c_evt_type evt_c,
  input wire irq_bank_pkg::flags_d_evt_type evt_d,
  input wire irq_bank_pkg::flags_e_evt_type evt_e,
  // neighbouring registers
  input wire logic [15:0] enables_b_in,
  input wire logic [15:0] enables_c_in,
  input wire logic [15:0] enables_d_in,
  input wire logic [15:0] enables_e_in,
  input wire logic [15:0] flags_a_in,
  // register contents toward arbitration
  output logic [15:0] irq_flags_b,
  output logic [15:0] irq_flags_c,
  output logic [15:0] irq_flags_d,
  output logic [15:0] irq_flags_e,
  output logic [15:0] irq_enables_a,
  // requests toward arbitration
  output logic [15:0] req_a,
  output logic [15:0] req_b,
  output logic [15:0] req_c,
  output logic [15:0] req_d,
  output logic [15:0] req_e,
  output logic irq_pending
);

  // ==========================================================
  // address decode
  typedef enum logic [2:0] {
    SEL_B = 3'h0,
    SEL_C = 3'h1,
    SEL_D = 3'h3,
    SEL_E = 3'h2,
    SEL_EN_A = 3'h6,
    SEL_PEND = 3'h7,
    SEL_NONE = 3'h5
  } reg_sel_type;

  function automatic reg_sel_type decode(input logic [4:0] addr);
    reg_sel_type sel;
    sel = SEL_NONE;
    case (addr)
      `FLAGS_B_OFS: sel = SEL_B;
      `FLAGS_C_OFS: sel = SEL_C;
      `FLAGS_D_OFS: sel = SEL_D;
      `FLAGS_E_OFS: sel = SEL_E;
      `ENABLES_A_OFS: sel = SEL_EN_A;
      `PENDING_OFS: sel = SEL_PEND;
      default: sel = SEL_NONE;
    endcase
    return sel;
  endfunction : decode

  // ==========================================================
  // bus handshake
  // every access takes one wait cycle; readdata is registered in it so the
  // read mux stays off the bus timing path
  logic ack_q;
  logic [31:0] readdata_q;
  logic access;
  logic wr_take;
  reg_sel_type sel;
  logic [5:0] pend_summary;
  logic [15:0] read_word;

  assign access = avs_req.read | avs_req.write;
  assign sel = decode(avs_req.address);
  assign wr_take = avs_req.write & ack_q;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= access & ~ack_q;
    end
  end

  assign avs_rsp.waitrequest = access & ~ack_q;
  assign avs_rsp.readdata = readdata_q;

  // ==========================================================
  // registers
  logic [15:0] set_b;
  logic [15:0] set_c;
  logic [15:0] set_d;
  logic [15:0] set_e;

  // spare positions are tied off here as well as masked in the register,
  // so a stray source bit can never reach a flop
  assign set_b = {
    12'h000,
    evt_b.pin_change_flag,
    1'b0,
    evt_b.i2c_a_master_flag,
    evt_b.i2c_a_slave_flag
  };

  assign set_c = {
    evt_c.timer_six_flag,
    evt_c.dma_ch4_done_flag,
    1'b0,
    evt_c.ocmp_8_to_5_flag,
    evt_c.icap_6_flag,
    evt_c.icap_5_to_3_flag,
    evt_c.dma_ch3_done_flag,
    evt_c.can_a_event_flag,
    evt_c.can_a_rx_ready_flag,
    evt_c.spi_b_event_flag,
    evt_c.spi_b_error_flag
  };

  assign set_d = {
    2'b00,
    evt_d.dma_ch5_done_flag,
    evt_d.codec_if_event_flag,
    evt_d.codec_if_error_flag,
    2'b00,
    evt_d.can_b_event_flag,
    evt_d.can_b_rx_ready_flag,
    evt_d.ext_irq4_flag,
    evt_d.ext_irq3_flag,
    evt_d.timer_nine_flag,
    evt_d.timer_eight_flag,
    evt_d.i2c_b_master_flag,
    evt_d.i2c_b_slave_flag,
    evt_d.timer_seven_flag
  };

  assign set_e = {
    8'h00,
    evt_e.can_b_tx_request_flag,
    evt_e.can_a_tx_request_flag,
    evt_e.dma_ch7_done_flag,
    evt_e.dma_ch6_done_flag,
    1'b0,
    evt_e.uart_b_error_flag,
    evt_e.uart_a_error_flag,
    1'b0
  };

  irq_bit_reg #(
    .IMPL_MASK(`FLAGS_B_MASK),
    .RST_VAL(`FLAGS_B_RST)
  ) u_flags_b (
    .ref_clk(ref_clk),
    .rst(rst),
    .wr_en(wr_take && sel == SEL_B),
    .wr_be(avs_req.byteenable[1:0]),
    .wr_data(avs_req.writedata[15:0]),
    .set_bits(set_b),
    .bits_q(irq_flags_b)
  );

  irq_bit_reg #(
    .IMPL_MASK(`FLAGS_C_MASK),
    .RST_VAL(`FLAGS_C_RST)
  ) u_flags_c (
    .ref_clk(ref_clk),
    .rst(rst),
    .wr_en(wr_take && sel == SEL_C),
    .wr_be(avs_req.byteenable[1:0]),
    .wr_data(avs_req.writedata[15:0]),
    .set_bits(set_c),
    .bits_q(irq_flags_c)
  );

  irq_bit_reg #(
    .IMPL_MASK(`FLAGS_D_MASK),
    .RST_VAL(`FLAGS_D_RST)
  ) u_flags_d (
    .ref_clk(ref_clk),
    .rst(rst),
    .wr_en(wr_take && sel == SEL_D),
    .wr_be(avs_req.byteenable[1:0]),
    .wr_data(avs_req.writedata[15:0]),
    .set_bits(set_d),
    .bits_q(irq_flags_d)
  );

  irq_bit_reg #(
    .IMPL_MASK(`FLAGS_E_MASK),
    .RST_VAL(`FLAGS_E_RST)
  ) u_flags_e (
    .ref_clk(ref_clk),
    .rst(rst),
    .wr_en(wr_take && sel == SEL_E),
    .wr_be(avs_req.byteenable[1:0]),
    .wr_data(avs_req.writedata[15:0]),
    .set_bits(set_e),
    .bits_q(irq_flags_e)
  );

  // enables have no hardware set
  irq_bit_reg #(
    .IMPL_MASK(`ENABLES_A_MASK),
    .RST_VAL(`ENABLES_A_RST)
  ) u_enables_a (
    .ref_clk(ref_clk),
    .rst(rst),
    .wr_en(wr_take && sel == SEL_EN_A),
    .wr_be(avs_req.byteenable[1:0]),
    .wr_data(avs_req.writedata[15:0]),
    .set_bits(16'h0000),
    .bits_q(irq_enables_a)
  );

  // ==========================================================
  // request gating
  logic any_a;
  logic any_b;
  logic any_c;
  logic any_d;
  logic any_e;

  irq_req_gate u_gate_a (
    .flags(flags_a_in),
    .enables(irq_enables_a),
    .req(req_a),
    .any_req(any_a)
  );

  irq_req_gate u_gate_b (
    .flags(irq_flags_b),
    .enables(enables_b_in),
    .req(req_b),
    .any_req(any_b)
  );

  irq_req_gate u_gate_c (
    .flags(irq_flags_c),
    .enables(enables_c_in),
    .req(req_c),
    .any_req(any_c)
  );

  irq_req_gate u_gate_d (
    .flags(irq_flags_d),
    .enables(enables_d_in),
    .req(req_d),
    .any_req(any_d)
  );

  irq_req_gate u_gate_e (
    .flags(irq_flags_e),
    .enables(enables_e_in),
    .req(req_e),
    .any_req(any_e)
  );

  assign irq_pending = any_a | any_b | any_c | any_d | any_e;
  assign pend_summary = {irq_pending, any_e, any_d, any_c, any_b, any_a};

  // ==========================================================
  // read path
  // unmapped offsets and the upper half-word read zero
  always_comb begin
    case (sel)
      SEL_B: read_word = irq_flags_b;
      SEL_C: read_word = irq_flags_c;
      SEL_D: read_word = irq_flags_d;
      SEL_E: read_word = irq_flags_e;
      SEL_EN_A: read_word = irq_enables_a;
      SEL_PEND: read_word = {10'h000, pend_summary};
      default: read_word = 16'h0000;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      readdata_q <= 32'h0000_0000;
    end else if (avs_req.read && !ack_q) begin
      readdata_q <= {16'h0000, read_word};
    end
  end

endmodule : irq_flag_enable_bank

// ### design/irq_bank_regs.svh
/*
  Register offsets, implemented-bit masks and reset values of the
  interrupt flag and enable bank.
  Assumes byte addressing on a 32-bit Avalon-MM slave, one word per register.
*/
`ifndef IRQ_BANK_REGS_SVH
`define IRQ_BANK_REGS_SVH

// ==========================================================
// byte offsets
`define FLAGS_B_OFS 5'h00
`define FLAGS_C_OFS 5'h04
`define FLAGS_D_OFS 5'h08
`define FLAGS_E_OFS 5'h0C
`define ENABLES_A_OFS 5'h10
`define PENDING_OFS 5'h14

// ==========================================================
// implemented bits, everything else reads zero and ignores writes
`define FLAGS_B_MASK 16'h000B
`define FLAGS_C_MASK 16'hDFFF
`define FLAGS_D_MASK 16'h39FF
`define FLAGS_E_MASK 16'h00F6
`define ENABLES_A_MASK 16'h7FFF

// ==========================================================
// reset values
`define FLAGS_B_RST 16'h0000
`define FLAGS_C_RST 16'h0000
`define FLAGS_D_RST 16'h0000
`define FLAGS_E_RST 16'h0000
`define ENABLES_A_RST 16'h0000

`endif

// ### design/irq_bank_pkg.sv
/*
  Types of the interrupt flag and enable bank: one packed event struct per
  flag register, bit for bit in register order, and the Avalon-MM carriers.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package irq_bank_pkg;

  // ==========================================================
  // event sources, msb first
  typedef struct packed {
    logic pin_change_flag;
    logic spare_2;
    logic i2c_a_master_flag;
    logic i2c_a_slave_flag;
  } flags_b_evt_type;

  typedef struct packed {
    logic timer_six_flag;
    logic dma_ch4_done_flag;
    logic spare_13;
    logic [3:0] ocmp_8_to_5_flag;
    logic icap_6_flag;
    logic [2:0] icap_5_to_3_flag;
    logic dma_ch3_done_flag;
    logic can_a_event_flag;
    logic can_a_rx_ready_flag;
    logic spi_b_event_flag;
    logic spi_b_error_flag;
  } flags_c_evt_type;

  typedef struct packed {
    logic [1:0] spare_15_14;
    logic dma_ch5_done_flag;
    logic codec_if_event_flag;
    logic codec_if_error_flag;
    logic [1:0] spare_10_9;
    logic can_b_event_flag;
    logic can_b_rx_ready_flag;
    logic ext_irq4_flag;
    logic ext_irq3_flag;
    logic timer_nine_flag;
    logic timer_eight_flag;
    logic i2c_b_master_flag;
    logic i2c_b_slave_flag;
    logic timer_seven_flag;
  } flags_d_evt_type;

  typedef struct packed {
    logic [7:0] spare_15_8;
    logic can_b_tx_request_flag;
    logic can_a_tx_request_flag;
    logic dma_ch7_done_flag;
    logic dma_ch6_done_flag;
    logic spare_3;
    logic uart_b_error_flag;
    logic uart_a_error_flag;
    logic spare_0;
  } flags_e_evt_type;

  // ==========================================================
  // register bus carriers
  typedef struct packed {
    logic [4:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } avmm_req_type;

  typedef struct packed {
    logic [31:0] readdata;
    logic waitrequest;
  } avmm_rsp_type;

endpackage : irq_bank_pkg

// ### design/irq_bit_reg.sv
/*
  One 16-bit software-visible bit register with hardware set inputs.
  Assumes set pulses and the write strobe are on ref_clk.
*/
`timescale 1ns/1ns
module irq_bit_reg #(
  parameter logic [15:0] IMPL_MASK = 16'hFFFF,
  parameter logic [15:0] RST_VAL = 16'h0000
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // software write
  input wire logic wr_en,
  input wire logic [1:0] wr_be,
  input wire logic [15:0] wr_data,
  // hardware set
  input wire logic [15:0] set_bits,
  // contents
  output logic [15:0] bits_q
);

  logic [15:0] bits_d;

  always_comb begin
    bits_d = bits_q;
    if (wr_en) begin
      if (wr_be[0]) begin
        bits_d[7:0] = wr_data[7:0];
      end
      if (wr_be[1]) begin
        bits_d[15:8] = wr_data[15:8];
      end
    end
    // a set in the same cycle as a clearing write wins
    bits_d = (bits_d | set_bits) & IMPL_MASK;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      bits_q <= RST_VAL & IMPL_MASK;
    end else begin
      bits_q <= bits_d;
    end
  end

endmodule : irq_bit_reg

// ### design/irq_req_gate.sv
/*
  Combines pending flags with their enables into requests.
  Assumes both inputs are registered on ref_clk.
*/
`timescale 1ns/1ns
module irq_req_gate (
  // inputs
  input wire logic [15:0] flags,
  input wire logic [15:0] enables,
  // requests
  output logic [15:0] req,
  output logic any_req
);

  assign req = flags & enables;
  assign any_req = |req;

endmodule : irq_req_gate

// ### test/irq_bank_sva.sv
/*
  Port assertions for the flag and enable bank.
  Assumes the bank's register header is on the include path.
*/
`timescale 1ns/1ns
`include "irq_bank_regs.svh"
module irq_bank_sva (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // register bus
  input wire irq_bank_pkg::avmm_req_type avs_req,
  input wire irq_bank_pkg::avmm_rsp_type avs_rsp,
  // sources and neighbours
  input wire irq_bank_pkg::flags_c_evt_type evt_c,
  input wire logic [15:0] enables_b_in,
  input wire logic [15:0] flags_a_in,
  // contents and requests
  input wire logic [15:0] irq_flags_b,
  input wire logic [15:0] irq_flags_c,
  input wire logic [15:0] irq_enables_a,
  input wire logic [15:0] req_a,
  input wire logic [15:0] req_b
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  logic wr_done;
  // a write only lands at the edge that sees waitrequest low
  assign wr_done = avs_req.write && !avs_rsp.waitrequest;
  // ==========================================================
  // checks
  AST_REQ_A: assert property (req_a == (flags_a_in & irq_enables_a))
    else $error("req_a not flags and enables");
  AST_REQ_B: assert property (req_b == (irq_flags_b & enables_b_in))
    else $error("req_b not flags and enables");
  AST_UNUSED: assert property (((irq_flags_b & ~`FLAGS_B_MASK) | (irq_flags_c &
    ~`FLAGS_C_MASK) | (irq_enables_a & ~`ENABLES_A_MASK)) == 16'h0000)
    else $error("absent bit set");
  AST_EVT_SET: assert property (|(evt_c & `FLAGS_C_MASK) |=>
    (irq_flags_c & $past(evt_c) & `FLAGS_C_MASK) == ($past(evt_c) & `FLAGS_C_MASK))
    else $error("event did not set flag");
  AST_STICKY: assert property (!wr_done |=>
    (irq_flags_c & $past(irq_flags_c)) == $past(irq_flags_c))
    else $error("flag dropped without write");
  AST_RESET: assert property ($fell(rst) |->
    (irq_flags_b | irq_flags_c | irq_enables_a) == 16'h0000)
    else $error("register not cleared by reset");
  AST_WR_EN: assert property (wr_done && avs_req.address == `ENABLES_A_OFS &&
    avs_req.byteenable[1:0] == 2'b11 |=>
    irq_enables_a == ($past(avs_req.writedata[15:0]) & `ENABLES_A_MASK))
    else $error("enable write lost");
  AST_WAIT: assert property ((avs_req.read || avs_req.write) && avs_rsp.waitrequest
    |=> !avs_rsp.waitrequest)
    else $error("waitrequest held too long");
endmodule : irq_bank_sva

bind irq_flag_enable_bank irq_bank_sva u_sva (.ref_clk(ref_clk), .rst(rst),
  .avs_req(avs_req), .avs_rsp(avs_rsp), .evt_c(evt_c), .enables_b_in(enables_b_in),
  .flags_a_in(flags_a_in), .irq_flags_b(irq_flags_b), .irq_flags_c(irq_flags_c),
  .irq_enables_a(irq_enables_a), .req_a(req_a), .req_b(req_b));

// ### test/periph_model.sv
/*
  Peripheral event sources: one-cycle pulses into one flag register.
  Assumes callers enter pulse just after a rising edge.
*/
`timescale 1ns/1ns
module periph_model (
  // clock
  input wire logic ref_clk,
  // event pulses
  output irq_bank_pkg::flags_b_evt_type evt_b,
  output irq_bank_pkg::flags_c_evt_type evt_c,
  output irq_bank_pkg::flags_d_evt_type evt_d,
  output irq_bank_pkg::flags_e_evt_type evt_e
);
  initial {evt_b, evt_c, evt_d, evt_e} = '0;
  task pulse(input int r, input logic [15:0] v);
    case (r)
      0: evt_b <= v[3:0];
      1: evt_c <= v;
      2: evt_d <= v;
      default: evt_e <= v;
    endcase
    @(posedge ref_clk);
    // only the pulsed source is lowered, so a pulse into another register
    // at this same edge is not overwritten
    case (r)
      0: evt_b <= '0;
      1: evt_c <= '0;
      2: evt_d <= '0;
      default: evt_e <= '0;
    endcase
  endtask : pulse
endmodule : periph_model

// ### test/testbench.sv
/*
  Self-checking bench for the flag and enable bank.
  Assumes the register header is on the include path.
*/
`timescale 1ns/1ns
`include "irq_bank_regs.svh"
module testbench;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  irq_bank_pkg::avmm_req_type req = '0;
  irq_bank_pkg::avmm_rsp_type rsp;
  irq_bank_pkg::flags_b_evt_type eb;
  irq_bank_pkg::flags_c_evt_type ec;
  irq_bank_pkg::flags_d_evt_type ed;
  irq_bank_pkg::flags_e_evt_type ee;
  logic [15:0] nb = 16'h0000;
  logic [15:0] fa = 16'h0000;
  logic [15:0] ra, rb, rc, rd, re;
  wire [15:0] fl [5];
  logic pend;
  int n_errors = 0;
  int check_count = 0;
  logic [31:0] q;
  logic [4:0] ofs [5] = '{`FLAGS_B_OFS, `FLAGS_C_OFS, `FLAGS_D_OFS, `FLAGS_E_OFS,
    `ENABLES_A_OFS};
  logic [15:0] msk [5] = '{`FLAGS_B_MASK, `FLAGS_C_MASK, `FLAGS_D_MASK, `FLAGS_E_MASK,
    `ENABLES_A_MASK};
  always #25 ref_clk = ~ref_clk;
  irq_flag_enable_bank uut (.ref_clk(ref_clk), .rst(rst), .avs_req(req), .avs_rsp(rsp),
    .evt_b(eb), .evt_c(ec), .evt_d(ed), .evt_e(ee), .enables_b_in(nb), .enables_c_in(nb),
    .enables_d_in(nb), .enables_e_in(nb), .flags_a_in(fa), .irq_flags_b(fl[0]),
    .irq_flags_c(fl[1]), .irq_flags_d(fl[2]), .irq_flags_e(fl[3]), .irq_enables_a(fl[4]),
    .req_a(ra),
    .req_b(rb), .req_c(rc), .req_d(rd), .req_e(re), .irq_pending(pend));
  periph_model pm (.ref_clk(ref_clk), .evt_b(eb), .evt_c(ec), .evt_d(ed), .evt_e(ee));
  // ==========================================================
  // helpers
  task give_verdict;
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : give_verdict
  task chk(input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %0t saw %h want %h", $time, seen, exp);
    end
  endtask : chk
  // holds the request until waitrequest is seen low, then lets one edge pass
  task bus(input logic [4:0] a, input logic rdn, input logic [15:0] d, input logic [1:0] be);
    int n;
    n = 0;
    req.address <= a;
    req.read <= rdn;
    req.write <= !rdn;
    req.writedata <= {16'h0000, d};
    req.byteenable <= {2'b00, be};
    do begin
      @(posedge ref_clk);
      n++;
    end while (rsp.waitrequest !== 1'b0 && n < 20);
    q = rsp.readdata;
    req.read <= 1'b0;
    req.write <= 1'b0;
    if (n >= 20) chk(1, 0);
    @(posedge ref_clk);
  endtask : bus
  task wr(input logic [4:0] a, input logic [15:0] d, input logic [1:0] be = 2'b11);
    bus(a, 1'b0, d, be);
  endtask : wr
  task rd_chk(input logic [4:0] a, input logic [15:0] e);
    bus(a, 1'b1, 16'h0000, 2'b11);
    chk(q, {16'h0000, e});
  endtask : rd_chk
  // ==========================================================
  // tests
  initial begin
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    for (int i = 0; i < 5; i++) rd_chk(ofs[i], 16'h0000);
    rd_chk(`PENDING_OFS, 16'h0000);
    $display("test reset done");
    for (int i = 0; i < 5; i++) begin
      wr(ofs[i], 16'hFFFF);
      rd_chk(ofs[i], msk[i]);
      wr(ofs[i], 16'h0000);
      rd_chk(ofs[i], 16'h0000);
    end
    wr(5'h18, 16'hFFFF);
    rd_chk(5'h18, 16'h0000);
    $display("test access done");
    for (int r = 0; r < 4; r++) begin
      for (int b = 0; b < 16; b++) begin
        pm.pulse(r, 16'h0001 << b);
        rd_chk(ofs[r], (16'h0001 << b) & msk[r]);
        chk(fl[r], (16'h0001 << b) & msk[r]);
        wr(ofs[r], 16'h0000);
      end
    end
    // event lands at the same edge as a clearing write: the set must win
    fork
      wr(ofs[1], 16'h0000);
      begin
        @(posedge ref_clk);
        pm.pulse(1, 16'h0001);
      end
    join
    rd_chk(ofs[1], 16'h0001);
    wr(ofs[1], 16'h0000);
    $display("test flags done");
    for (int r = 0; r < 4; r++) pm.pulse(r, 16'hFFFF);
    @(negedge ref_clk);
    chk(pend, 0);
    chk({fl[0], fl[1], fl[2], fl[3]}, {msk[0], msk[1], msk[2], msk[3]});
    @(posedge ref_clk);
    nb <= 16'hFFFF;
    @(negedge ref_clk);
    chk({rb, rc, rd, re}, {msk[0], msk[1], msk[2], msk[3]});
    @(posedge ref_clk);
    rd_chk(`PENDING_OFS, 16'h003E);
    for (int r = 0; r < 4; r++) wr(ofs[r], 16'h0000);
    rd_chk(`PENDING_OFS, 16'h0000);
    $display("test requests done");
    fa <= 16'hFFFF;
    wr(`ENABLES_A_OFS, 16'hFFFF);
    rd_chk(`PENDING_OFS, 16'h0021);
    @(negedge ref_clk);
    chk(ra, 16'h7FFF);
    @(posedge ref_clk);
    wr(`ENABLES_A_OFS, 16'h0000, 2'b01);
    rd_chk(`ENABLES_A_OFS, 16'h7F00);
    chk(fl[4], 16'h7F00);
    chk(ra, 16'h7F00);
    $display("test enables done");
    give_verdict;
  end
  initial begin
    repeat (5000) @(posedge ref_clk);
    n_errors++;
    give_verdict;
  end
endmodule : testbench
